// [hw/sbabt_pkg.sv]
// Constants, field layout and types of the serial bus arbiter bit timer.
// Assumes an AXI4-Lite master with 32-bit data and a 4-bit byte address.

package sbabt_pkg;

    // Register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h4;

    // Control/status bit positions
    localparam int B_AM1 = 7;
    localparam int B_LOST = 6;
    localparam int B_AM0 = 5;
    localparam int B_ACLK = 4;
    localparam int B_FIN = 3;
    localparam int B_RUN = 2;
    localparam int B_OVF = 1;
    localparam int B_MSB = 0;

    // Modes
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_MEASURE = 2'h1;
    localparam logic [1:0] MODE_ARB = 2'h2;

    // Counter and timing
    localparam logic [8:0] CNT_RST = 9'h000;
    localparam logic [8:0] CNT_MAX = 9'h1FF;
    localparam logic [8:0] SAMPLE_BUS = 9'h038;
    localparam logic [8:0] SAMPLE_PRE = 9'h008;
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    localparam logic [7:0] PRE_RST = 8'h00;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

    typedef struct packed {
        logic [1:0] mode;
        logic aclk_sel;
    } sbabt_ctrl_t;

    typedef enum logic [1:0] {PH_WAIT, PH_COUNT, PH_DONE} sbabt_phase_t;

endpackage

// [hw/sbabt_top.sv]
// Serial bus arbiter bit timer with its AXI4-Lite register slave.
// Assumes receive and transmit signals synchronous to aclk; crystal tick
// is a one-cycle enable pulse; the strap is static after reset.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps

module sbabt_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxd,
    input wire logic internal_transmit_output,
    input wire logic crystal_clock_tick,
    input wire logic baud_source_select,
    input wire logic [7:0] prescaler_divisor,
    output logic tx_pin
);

    function automatic logic addr_ok(input logic [3:0] a);
        addr_ok = (a == sbabt_pkg::ADDR_CTRL) || (a == sbabt_pkg::ADDR_DATA);
    endfunction

    sbabt_pkg::sbabt_ctrl_t ctrl;
    sbabt_pkg::sbabt_phase_t phase;
    sbabt_pkg::sbabt_phase_t next_phase;
    logic [8:0] cnt;
    logic fin;
    logic ovf;
    logic lost;
    logic sampled;
    logic rx_low_seen;
    logic rx_q;
    logic tx_q;
    logic src_sel;
    logic strap_done;
    logic [7:0] pre_cnt;
    logic aw_have;
    logic w_have;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_lane0_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode and events

    logic meas;
    logic arb;
    logic rx_fall;
    logic rx_rise;
    logic tx_rise;
    logic tx_fall;
    logic wr_do;
    logic wr;
    logic wr_clr_lost;
    logic start;
    logic stop;
    logic arb_abort;
    logic cnt_clear;
    logic cnt_inc;
    logic tick;
    logic pre_tick;
    logic src_en;
    logic [8:0] target;
    logic sample_hit;
    logic [1:0] quarter_tick;
    logic [1:0] div_en;

    assign meas = ctrl.mode == sbabt_pkg::MODE_MEASURE;
    assign arb = ctrl.mode == sbabt_pkg::MODE_ARB;
    assign rx_fall = rx_q && !rxd;
    assign rx_rise = !rx_q && rxd;
    assign tx_rise = !tx_q && internal_transmit_output;
    assign tx_fall = tx_q && !internal_transmit_output;
    assign wr_do = aw_have && w_have && !s_axi_bvalid;
    assign wr = wr_do && w_lane0_q && (aw_addr_q == sbabt_pkg::ADDR_CTRL);
    assign wr_clr_lost = wr && !w_data_q[sbabt_pkg::B_AM1];

    // Measurement start and stop conditions
    assign start = ctrl.aclk_sel ? !rxd : rx_fall;
    assign stop = meas && (phase == sbabt_pkg::PH_COUNT)
        && (ctrl.aclk_sel ? rx_rise : rx_fall);

    assign arb_abort = arb && (phase == sbabt_pkg::PH_COUNT) && tx_fall
        && !rx_low_seen;

    assign cnt_clear = !(meas || arb) || wr || (arb && tx_rise) || arb_abort
        || (meas && phase == sbabt_pkg::PH_WAIT);
    assign cnt_inc = !cnt_clear && !stop && tick
        && (phase == sbabt_pkg::PH_COUNT);

    assign target = ctrl.aclk_sel ? sbabt_pkg::SAMPLE_PRE
        : sbabt_pkg::SAMPLE_BUS;
    assign sample_hit = arb && (phase == sbabt_pkg::PH_COUNT)
        && (cnt == target) && !sampled && !rxd;

    ////////////////////////////////////////////////////////////////////////
    // Counter clock enables

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_sel <= 1'b0;
            strap_done <= 1'b0;
        end
        else if (!strap_done)
        begin
            src_sel <= baud_source_select;
            strap_done <= 1'b1;
        end
    end

    assign src_en = src_sel ? crystal_clock_tick : 1'b1;
    // Compare with >= so a smaller divisor never sends the count round 256
    assign pre_tick = src_en && (pre_cnt >= prescaler_divisor);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pre_cnt <= sbabt_pkg::PRE_RST;
        else if (pre_tick)
            pre_cnt <= sbabt_pkg::PRE_RST;
        else if (src_en)
            pre_cnt <= pre_cnt + 8'h01;
    end

    assign div_en = {pre_tick, 1'b1};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_quarter
            logic [1:0] q;
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    q <= 2'h0;
                else if (div_en[gi])
                    q <= q + 2'h1;
            end
            assign quarter_tick[gi] = div_en[gi]
                && (q == sbabt_pkg::QUARTER_LAST);
        end
    endgenerate

    assign tick = ctrl.aclk_sel ? quarter_tick[1] : quarter_tick[0];

    ////////////////////////////////////////////////////////////////////////
    // Phase machine

    always_comb
    begin
        next_phase = phase;
        if (!(meas || arb) || wr)
            next_phase = sbabt_pkg::PH_WAIT;
        else if (arb)
        begin
            if (tx_rise)
                next_phase = sbabt_pkg::PH_COUNT;
            else if (arb_abort)
                next_phase = sbabt_pkg::PH_WAIT;
        end
        else
        begin
            case (phase)
                sbabt_pkg::PH_WAIT:
                    if (start)
                        next_phase = sbabt_pkg::PH_COUNT;
                sbabt_pkg::PH_COUNT:
                    if (stop)
                        next_phase = sbabt_pkg::PH_DONE;
                sbabt_pkg::PH_DONE:
                    next_phase = sbabt_pkg::PH_DONE;
                default:
                    next_phase = sbabt_pkg::PH_WAIT;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            phase <= sbabt_pkg::PH_WAIT;
        else
            phase <= next_phase;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter and flags

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt <= sbabt_pkg::CNT_RST;
        else if (cnt_clear)
            cnt <= sbabt_pkg::CNT_RST;
        else if (cnt_inc)
            cnt <= cnt + 9'h001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ovf <= 1'b0;
            fin <= 1'b0;
            lost <= 1'b0;
        end
        else
        begin
            if (cnt_inc && cnt == sbabt_pkg::CNT_MAX)
                ovf <= 1'b1;
            else if (wr)
                ovf <= 1'b0;
            if (stop)
                fin <= 1'b1;
            else if (wr)
                fin <= 1'b0;
            if (sample_hit)
                lost <= 1'b1;
            else if (wr_clr_lost)
                lost <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sampled <= 1'b0;
            rx_low_seen <= 1'b0;
        end
        else if (tx_rise || !arb)
        begin
            sampled <= 1'b0;
            rx_low_seen <= 1'b0;
        end
        else
        begin
            if (phase == sbabt_pkg::PH_COUNT && cnt == target)
                sampled <= 1'b1;
            if (!rxd)
                rx_low_seen <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_q <= 1'b1;
            tx_q <= 1'b1;
            tx_pin <= 1'b1;
        end
        else
        begin
            rx_q <= rxd;
            tx_q <= internal_transmit_output;
            tx_pin <= lost || internal_transmit_output;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl.mode <= sbabt_pkg::MODE_IDLE;
            ctrl.aclk_sel <= 1'b0;
        end
        else if (wr)
        begin
            ctrl.mode <= {w_data_q[sbabt_pkg::B_AM1],
                w_data_q[sbabt_pkg::B_AM0]};
            ctrl.aclk_sel <= w_data_q[sbabt_pkg::B_ACLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= sbabt_pkg::RDATA_RST;
            w_lane0_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sbabt_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_lane0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_do)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_addr_q) ? sbabt_pkg::RESP_OKAY
                    : sbabt_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= sbabt_pkg::RDATA_RST;
            s_axi_rresp <= sbabt_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_ok(s_axi_araddr) ? sbabt_pkg::RESP_OKAY
                : sbabt_pkg::RESP_SLVERR;
            s_axi_rdata <= sbabt_pkg::RDATA_RST;
            if (s_axi_araddr == sbabt_pkg::ADDR_CTRL)
                s_axi_rdata[7:0] <= {ctrl.mode[1], lost, ctrl.mode[0],
                    ctrl.aclk_sel, fin, phase == sbabt_pkg::PH_COUNT,
                    ovf, cnt[8]};
            else if (s_axi_araddr == sbabt_pkg::ADDR_DATA)
                s_axi_rdata[7:0] <= cnt[7:0];
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_IDLE_CLEAR: assert property (
        !(meas || arb) |=> cnt == 9'h000 && phase != sbabt_pkg::PH_COUNT)
        else $error("idle mode left counter running");

    AST_WRITE_CLEARS: assert property (
        wr && !stop && !(cnt_inc && cnt == sbabt_pkg::CNT_MAX)
        |=> cnt == 9'h000 && !fin && !ovf)
        else $error("control write did not clear counter and flags");

    AST_LOST_HOLD: assert property (
        lost && !wr_clr_lost |=> lost)
        else $error("lost flag cleared without upper mode bit zero");

    AST_TX_FORCED: assert property (
        lost |=> tx_pin)
        else $error("transmit not forced high while lost");

    AST_OVF_SET: assert property (
        cnt_inc && cnt == sbabt_pkg::CNT_MAX |=> ovf && cnt == 9'h000)
        else $error("counter wrap did not set overflow");

    AST_FALL_STOP: assert property (
        meas && !ctrl.aclk_sel && phase == sbabt_pkg::PH_COUNT && rx_fall
        |=> fin && phase != sbabt_pkg::PH_COUNT)
        else $error("second falling edge did not finish measurement");

    AST_LOW_START: assert property (
        meas && ctrl.aclk_sel && phase == sbabt_pkg::PH_WAIT && !rxd && !wr
        |=> phase == sbabt_pkg::PH_COUNT)
        else $error("low receive did not start break count");

    AST_RISE_STOP: assert property (
        meas && ctrl.aclk_sel && phase == sbabt_pkg::PH_COUNT && rx_rise
        && !wr
        |=> fin && phase == sbabt_pkg::PH_DONE ##1 ($stable(cnt) || $past(wr)))
        else $error("break count did not stop on rising edge");

    AST_ARB_RESTART: assert property (
        arb && tx_rise && !wr |=> phase == sbabt_pkg::PH_COUNT
        && cnt == 9'h000)
        else $error("transmit rise did not restart counter");

    AST_ARB_SAMPLE: assert property (
        sample_hit |=> lost ##1 tx_pin)
        else $error("low sample did not set lost");

    AST_ARB_ABORT: assert property (
        arb_abort && !wr |=> cnt == 9'h000 && phase == sbabt_pkg::PH_WAIT)
        else $error("unsensed transmit low did not reset counter");

    AST_BUS_QUARTER: assert property (
        quarter_tick[0] |=> !quarter_tick[0] [*3] ##1 quarter_tick[0])
        else $error("bus quarter tick spacing wrong");

    COV_BAUD: cover property (meas && !ctrl.aclk_sel && stop);
    COV_BREAK: cover property (meas && ctrl.aclk_sel && stop);
    COV_LOST: cover property (sample_hit);
    COV_OVF: cover property (cnt_inc && cnt == sbabt_pkg::CNT_MAX);

endmodule // sbabt_top

// [sim/sbabt_bus_peer.sv]
// Other transceiver on the shared wired-AND serial line.
// Assumes the bench commands its dominant drive in step with aclk.
`timescale 1ns/1ps

module sbabt_bus_peer
(
    input wire logic aclk,
    input wire logic tx_pin,
    input wire logic dominant,
    input wire logic [1:0] lag,
    output logic rxd
);
    logic [3:0] hist = 4'h0;
    logic drive_low;

    ////////////////////////////////////////////////////////////////////
    // Prompt peer at lag 0, slow peer delays its drive by lag cycles
    always_ff @(posedge aclk)
    begin
        hist <= {hist[2:0], dominant};
    end

    assign drive_low = (lag == 2'h0) ? dominant : hist[lag - 2'h1];
    // Pull-up idles the line high; any low driver wins
    assign rxd = tx_pin & ~drive_low;
endmodule // sbabt_bus_peer

// [sim/serial_bus_arbiter_bit_timer_tb.sv]
// Self-checking bench of the arbiter bit timer over AXI4-Lite.
// Assumes the peer model drives the receive line; strap goes high at the
// mid-run reset so the last break runs from crystal ticks.
`timescale 1ns/1ps

module serial_bus_arbiter_bit_timer_tb;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tx_pin, rxd;
    logic [1:0] s_axi_bresp, s_axi_rresp, peer_lag = 2'h0;
    logic internal_transmit_output = 1'h1, peer_dom = 1'h0;
    logic [7:0] prescaler_divisor = 8'h0;
    logic xtal_tick = 1'h0, strap = 1'h0;
    int fails = 0, check_count = 0, seed = 32'hEAFA, cyc = 0;

    always #20 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    always @(posedge aclk) xtal_tick <= ~xtal_tick;

    sbabt_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd,
        .internal_transmit_output, .crystal_clock_tick(xtal_tick),
        .baud_source_select(strap), .prescaler_divisor, .tx_pin);

    sbabt_bus_peer u_peer (.aclk, .tx_pin, .dominant(peer_dom),
        .lag(peer_lag), .rxd);

    ////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input int lo, input int hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'h1)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    // Reference count: four bus cycles per tick, prescaler divides first
    function automatic int exp_count(input int n, input int dv);
        return n / (4 * (dv + 1));
    endfunction

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1 && n < 50);
        if (n >= 50)
            fails++;
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1 && n < 50);
        if (n >= 50)
            fails++;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] v);
        logic [1:0] r;
        axi_wr(4'h0, {24'h0, v}, r);
        chk(r, sbabt_pkg::RESP_OKAY, sbabt_pkg::RESP_OKAY);
    endtask

    task automatic rd_cnt(output logic [7:0] c, output logic [8:0] cnt);
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
        axi_rd(4'h0, d, r);
        chk(r, sbabt_pkg::RESP_OKAY, sbabt_pkg::RESP_OKAY);
        axi_rd(4'h4, e, r);
        chk(r, sbabt_pkg::RESP_OKAY, sbabt_pkg::RESP_OKAY);
        c = d[7:0];
        cnt = {d[0], e[7:0]};
    endtask

    task automatic fall_pulse;
        @(posedge aclk);
        peer_dom <= 1'h1;
        repeat (4) @(posedge aclk);
        peer_dom <= 1'h0;
    endtask

    task automatic wait_to(input int t);
        while (cyc < t)
            @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        stop_test();
    end

    initial
    begin
        logic [1:0] r;
        logic [31:0] d;
        logic [7:0] c;
        logic [8:0] cnt;
        int n, t0, dv;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd_cnt(c, cnt);
        chk(c, 0, 0);
        chk(cnt, 0, 0);
        axi_rd(4'h8, d, r);
        chk(r, sbabt_pkg::RESP_SLVERR, sbabt_pkg::RESP_SLVERR);
        axi_wr(4'hC, 32'h20, r);
        chk(r, sbabt_pkg::RESP_SLVERR, sbabt_pkg::RESP_SLVERR);
        // Idle and reserved modes keep the counter cleared
        for (int i = 0; i < 2; i++)
        begin
            wr(i == 0 ? 8'h00 : 8'hA0);
            fall_pulse();
            repeat (40) @(posedge aclk);
            fall_pulse();
            rd_cnt(c, cnt);
            chk(cnt, 0, 0);
            chk(c[sbabt_pkg::B_RUN], 0, 0);
        end
        // Bit time, bus clock: fall to fall
        for (int i = 0; i < 3; i++)
        begin
            n = (i == 0) ? 1200 : 40 + $unsigned($random(seed)) % 800;
            wr(8'h20);
            fall_pulse();
            t0 = cyc;
            rd_cnt(c, cnt);
            chk(c[sbabt_pkg::B_RUN], 1, 1);
            wait_to(t0 + n - 1);
            fall_pulse();
            rd_cnt(c, cnt);
            chk(c[sbabt_pkg::B_FIN], 1, 1);
            chk(c[sbabt_pkg::B_RUN], 0, 0);
            // The two falls stand n + 4 cycles apart
            chk(cnt, exp_count(n + 4, 0) - 1, exp_count(n + 4, 0) + 1);
        end
        // A write to the count register leaves the frozen result alone
        axi_wr(4'h4, 32'h0, r);
        chk(r, sbabt_pkg::RESP_OKAY, sbabt_pkg::RESP_OKAY);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_FIN], 1, 1);
        wr(8'h20);
        rd_cnt(c, cnt);
        chk(c, 8'h20, 8'h20);
        chk(cnt, 0, 0);
        fall_pulse();
        repeat (2100) @(posedge aclk);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_OVF], 1, 1);
        chk(c[sbabt_pkg::B_RUN], 1, 1);
        wr(8'h20);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_OVF], 0, 0);
        // Break length, prescaled clock, line already low
        dv = $unsigned($random(seed)) % 4;
        n = 200 + $unsigned($random(seed)) % 400;
        prescaler_divisor <= dv[7:0];
        peer_dom <= 1'h1;
        wr(8'h30);
        t0 = cyc;
        wait_to(t0 + n);
        peer_dom <= 1'h0;
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_FIN], 1, 1);
        chk(c[sbabt_pkg::B_RUN], 0, 0);
        chk(cnt, exp_count(n, dv) - 1, exp_count(n, dv) + 1);
        // Arbitration, bus clock, slow peer dominant
        peer_lag <= 2'h2;
        internal_transmit_output <= 1'h0;
        wr(8'h80);
        internal_transmit_output <= 1'h1;
        peer_dom <= 1'h1;
        t0 = cyc;
        wait_to(t0 + 200);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_LOST], 0, 0);
        wait_to(t0 + 260);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_LOST], 1, 1);
        internal_transmit_output <= 1'h0;
        repeat (3) @(posedge aclk);
        chk(tx_pin, 1, 1);
        wr(8'h90);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_LOST], 1, 1);
        peer_dom <= 1'h0;
        wr(8'h00);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_LOST], 0, 0);
        chk(tx_pin, 0, 0);
        // Arbitration won, then transmit low with the line still high
        wr(8'h80);
        internal_transmit_output <= 1'h1;
        repeat (260) @(posedge aclk);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_LOST], 0, 0);
        chk(c[sbabt_pkg::B_RUN], 1, 1);
        internal_transmit_output <= 1'h0;
        repeat (4) @(posedge aclk);
        rd_cnt(c, cnt);
        chk(cnt, 0, 0);
        internal_transmit_output <= 1'h1;
        repeat (40) @(posedge aclk);
        rd_cnt(c, cnt);
        chk(cnt, 8, 13);
        // Arbitration on the prescaled clock samples at count 08h
        prescaler_divisor <= 8'h01;
        internal_transmit_output <= 1'h0;
        peer_lag <= 2'h0;
        wr(8'h90);
        internal_transmit_output <= 1'h1;
        peer_dom <= 1'h1;
        t0 = cyc;
        wait_to(t0 + 50);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_LOST], 0, 0);
        wait_to(t0 + 90);
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_LOST], 1, 1);
        peer_dom <= 1'h0;
        // Reset in mid-count clears everything again
        wr(8'h20);
        fall_pulse();
        repeat (30) @(posedge aclk);
        strap <= 1'h1;
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd_cnt(c, cnt);
        chk(c, 0, 0);
        chk(cnt, 0, 0);
        // Break length with the prescaler fed from crystal ticks
        n = 200 + $unsigned($random(seed)) % 400;
        prescaler_divisor <= 8'h00;
        peer_dom <= 1'h1;
        wr(8'h30);
        t0 = cyc;
        wait_to(t0 + n);
        peer_dom <= 1'h0;
        rd_cnt(c, cnt);
        chk(c[sbabt_pkg::B_FIN], 1, 1);
        chk(cnt, exp_count(n / 2, 0) - 1, exp_count(n / 2, 0) + 1);
        stop_test();
    end
endmodule // serial_bus_arbiter_bit_timer_tb
